// file: color_sensor_regs.sv
// Register map, command control and result store of the colour sensor
`timescale 1ns/1ps
module color_sensor_regs
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Register access from the serial interface
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Analog front end
   input wire logic afe_ack_i,
   input wire logic [9:0] afe_result_i,
   output logic afe_req_o,
   output logic afe_offset_mode_o,
   output logic [1:0] afe_chan_o,
   output logic [3:0] afe_cap_o,
   output logic [11:0] afe_int_o,
   // Clock, power and trim control
   output logic ext_clock_select_o,
   output logic sleep_o,
   output logic trim_offset_enable_o
);

   localparam int NCH = color_sensor_pkg::NUM_CHAN;
   localparam int CW = color_sensor_pkg::CAP_W;
   localparam int IW = color_sensor_pkg::INT_W;
   localparam int RW = color_sensor_pkg::RES_W;
   localparam int MW = color_sensor_pkg::MAG_W;

   // ==========================================================
   // Helpers

   // Hit when addr lies in [base, base + count)
   function automatic logic in_block(input logic [7:0] addr,
                                     input logic [7:0] base,
                                     input logic [7:0] count);
      logic [7:0] diff;
      diff = 8'(addr - base);
      in_block = (addr >= base) && (diff < count);
   endfunction

   // Offset of addr from base, cut to the block index width
   function automatic logic [2:0] block_idx(input logic [7:0] addr,
                                            input logic [7:0] base);
      logic [7:0] diff;
      diff = 8'(addr - base);
      block_idx = diff[2:0];
   endfunction

   // Removes a sign-magnitude offset from a raw reading, clamped
   function automatic logic [RW-1:0] trim_result(input logic [RW-1:0] raw,
                                                 input logic [7:0] ofs);
      logic [11:0] wide;
      logic [11:0] mag;
      wide = {2'b00, raw};
      mag = {5'h00, ofs[MW-1:0]};
      if (ofs[color_sensor_pkg::SIGN_BIT])
         wide = 12'(wide + mag);
      else
         wide = 12'(wide - mag);
      if (wide[11])
         trim_result = '0;
      else if (wide[11:10] != 2'b00)
         trim_result = '1;
      else
         trim_result = wide[RW-1:0];
   endfunction

   // ==========================================================
   // Storage
   logic conv_cmd_reg, conv_cmd_next;
   logic ofs_cmd_reg, ofs_cmd_next;
   logic ext_clk_next, sleep_next, trim_next;
   logic [CW-1:0] cap_reg [NCH];
   logic [CW-1:0] cap_next [NCH];
   logic [IW-1:0] int_reg [NCH];
   logic [IW-1:0] int_next [NCH];
   logic [RW-1:0] data_reg [NCH];
   logic [RW-1:0] data_next [NCH];
   logic [7:0] ofs_reg [NCH];
   logic [7:0] ofs_next [NCH];
   logic busy_reg, busy_next;
   logic run_ofs_reg, run_ofs_next;
   logic [7:0] rd_next;

   // ==========================================================
   // Address decode
   wire logic wr_ctrl;
   wire logic wr_cfg;
   wire logic hit_cap;
   wire logic hit_int;
   wire logic hit_data;
   wire logic hit_ofs;
   wire logic [2:0] cap_idx;
   wire logic [2:0] int_idx;
   wire logic [2:0] data_idx;
   wire logic [2:0] ofs_idx;

   assign wr_ctrl = reg_wr_i && (reg_addr_i == color_sensor_pkg::ADDR_CTRL);
   assign wr_cfg = reg_wr_i && (reg_addr_i == color_sensor_pkg::ADDR_CONFIG);
   assign hit_cap = in_block(reg_addr_i, color_sensor_pkg::ADDR_CAP_BASE,
                             8'(NCH));
   assign hit_int = in_block(reg_addr_i, color_sensor_pkg::ADDR_INT_BASE,
                             8'(2 * NCH));
   assign hit_data = in_block(reg_addr_i, color_sensor_pkg::ADDR_DATA_BASE,
                              8'(2 * NCH));
   assign hit_ofs = in_block(reg_addr_i, color_sensor_pkg::ADDR_OFS_BASE,
                             8'(NCH));
   assign cap_idx = block_idx(reg_addr_i, color_sensor_pkg::ADDR_CAP_BASE);
   assign int_idx = block_idx(reg_addr_i, color_sensor_pkg::ADDR_INT_BASE);
   assign data_idx = block_idx(reg_addr_i, color_sensor_pkg::ADDR_DATA_BASE);
   assign ofs_idx = block_idx(reg_addr_i, color_sensor_pkg::ADDR_OFS_BASE);

   // ==========================================================
   // Sequencer and offset formatting
   wire logic start;
   wire logic seq_done;
   wire logic store;
   wire logic [7:0] ofs_sm;

   // Conversion outranks offset; sleep holds new work back
   assign start = !busy_reg && !sleep_o && (conv_cmd_reg || ofs_cmd_reg);
   assign store = afe_req_o && afe_ack_i;

   channel_sequencer seq_u
   (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .start_i(start),
      .offset_mode_i(!conv_cmd_reg),
      .ack_i(afe_ack_i),
      .req_o(afe_req_o),
      .chan_o(afe_chan_o),
      .offset_mode_o(afe_offset_mode_o),
      .done_o(seq_done)
   );

   sign_mag_format fmt_u
   (
      .raw_i(afe_result_i[7:0]),
      .sm_o(ofs_sm)
   );

   // ==========================================================
   // Command bits
   always_comb
   begin
      busy_next = busy_reg;
      run_ofs_next = run_ofs_reg;
      conv_cmd_next = conv_cmd_reg;
      ofs_cmd_next = ofs_cmd_reg;
      if (start)
      begin
         busy_next = 1'b1;
         run_ofs_next = !conv_cmd_reg;
      end
      if (seq_done)
      begin
         busy_next = 1'b0;
         if (run_ofs_reg)
            ofs_cmd_next = 1'b0;
         else
            conv_cmd_next = 1'b0;
      end
      // A fresh request in the clearing cycle is kept
      if (wr_ctrl && reg_wdata_i[color_sensor_pkg::CONV_BIT])
         conv_cmd_next = 1'b1;
      if (wr_ctrl && reg_wdata_i[color_sensor_pkg::OFS_BIT])
         ofs_cmd_next = 1'b1;
   end

   // ==========================================================
   // Configuration
   always_comb
   begin
      ext_clk_next = ext_clock_select_o;
      trim_next = trim_offset_enable_o;
      sleep_next = sleep_o;
      if (wr_cfg)
      begin
         ext_clk_next = reg_wdata_i[color_sensor_pkg::EXT_CLOCK_SELECT_BIT];
         trim_next = reg_wdata_i[color_sensor_pkg::TRIM_BIT];
         sleep_next = reg_wdata_i[color_sensor_pkg::SLEEP_BIT];
      end
      // Also drops sleep if the external clock is later deselected
      sleep_next = sleep_next && ext_clk_next;
   end

   // ==========================================================
   // Settings and results
   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         cap_next[i] = cap_reg[i];
         int_next[i] = int_reg[i];
         data_next[i] = data_reg[i];
         ofs_next[i] = ofs_reg[i];
      end
      if (reg_wr_i && hit_cap)
         cap_next[cap_idx[1:0]] = reg_wdata_i[CW-1:0];
      if (reg_wr_i && hit_int)
      begin
         if (int_idx[0])
            int_next[int_idx[2:1]][IW-1:8] = reg_wdata_i[IW-9:0];
         else
            int_next[int_idx[2:1]][7:0] = reg_wdata_i;
      end
      if (store && afe_offset_mode_o)
         ofs_next[afe_chan_o] = ofs_sm;
      if (store && !afe_offset_mode_o)
      begin
         if (trim_offset_enable_o)
            data_next[afe_chan_o] =
               trim_result(afe_result_i, ofs_reg[afe_chan_o]);
         else
            data_next[afe_chan_o] = afe_result_i;
      end
   end

   // ==========================================================
   // Read data
   always_comb
   begin
      rd_next = color_sensor_pkg::BYTE_ZERO;
      if (reg_addr_i == color_sensor_pkg::ADDR_CTRL)
      begin
         rd_next[color_sensor_pkg::CONV_BIT] = conv_cmd_reg;
         rd_next[color_sensor_pkg::OFS_BIT] = ofs_cmd_reg;
      end
      else if (reg_addr_i == color_sensor_pkg::ADDR_CONFIG)
      begin
         rd_next[color_sensor_pkg::EXT_CLOCK_SELECT_BIT] = ext_clock_select_o;
         rd_next[color_sensor_pkg::SLEEP_BIT] = sleep_o;
         rd_next[color_sensor_pkg::TRIM_BIT] = trim_offset_enable_o;
      end
      else if (hit_cap)
         rd_next[CW-1:0] = cap_reg[cap_idx[1:0]];
      else if (hit_int && int_idx[0])
         rd_next[IW-9:0] = int_reg[int_idx[2:1]][IW-1:8];
      else if (hit_int)
         rd_next = int_reg[int_idx[2:1]][7:0];
      else if (hit_data && data_idx[0])
         rd_next[RW-9:0] = data_reg[data_idx[2:1]][RW-1:8];
      else if (hit_data)
         rd_next = data_reg[data_idx[2:1]][7:0];
      else if (hit_ofs)
         rd_next = ofs_reg[ofs_idx[1:0]];
   end

   // ==========================================================
   // Flip-flops
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         conv_cmd_reg <= 1'b0;
         ofs_cmd_reg <= 1'b0;
         busy_reg <= 1'b0;
         run_ofs_reg <= 1'b0;
         ext_clock_select_o <= 1'b0;
         sleep_o <= 1'b0;
         trim_offset_enable_o <= 1'b0;
         reg_rdata_o <= color_sensor_pkg::BYTE_ZERO;
      end
      else
      begin
         conv_cmd_reg <= conv_cmd_next;
         ofs_cmd_reg <= ofs_cmd_next;
         busy_reg <= busy_next;
         run_ofs_reg <= run_ofs_next;
         ext_clock_select_o <= ext_clk_next;
         sleep_o <= sleep_next;
         trim_offset_enable_o <= trim_next;
         if (reg_rd_i)
            reg_rdata_o <= rd_next;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            cap_reg[i] <= color_sensor_pkg::CAP_RESET;
            int_reg[i] <= color_sensor_pkg::INT_RESET;
            data_reg[i] <= color_sensor_pkg::RES_RESET;
            ofs_reg[i] <= color_sensor_pkg::BYTE_ZERO;
         end
      end
      else
      begin
         cap_reg <= cap_next;
         int_reg <= int_next;
         data_reg <= data_next;
         ofs_reg <= ofs_next;
      end
   end

   // Settings of the channel being set up, one cycle behind the channel
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         afe_cap_o <= color_sensor_pkg::CAP_RESET;
         afe_int_o <= color_sensor_pkg::INT_RESET;
      end
      else
      begin
         afe_cap_o <= cap_reg[afe_chan_o];
         afe_int_o <= int_reg[afe_chan_o];
      end
   end

endmodule

// file: color_sensor_pkg.sv
// Constants shared by the colour sensor register block and its helpers
package color_sensor_pkg;

   // ==========================================================
   // Register addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CONFIG = 8'h01;
   localparam logic [7:0] ADDR_CAP_BASE = 8'h06;
   localparam logic [7:0] ADDR_INT_BASE = 8'h0A;
   localparam logic [7:0] ADDR_DATA_BASE = 8'h40;
   localparam logic [7:0] ADDR_OFS_BASE = 8'h48;

   // ==========================================================
   // Field positions
   localparam int CONV_BIT = 0;
   localparam int OFS_BIT = 1;
   localparam int TRIM_BIT = 0;
   localparam int SLEEP_BIT = 1;
   localparam int EXT_CLOCK_SELECT_BIT = 2;
   localparam int SIGN_BIT = 7;

   // ==========================================================
   // Widths, counts and reset values
   localparam int NUM_CHAN = 4;
   localparam int CHAN_W = 2;
   localparam int CAP_W = 4;
   localparam int INT_W = 12;
   localparam int RES_W = 10;
   localparam int MAG_W = 7;
   localparam logic [CAP_W-1:0] CAP_RESET = 4'hF;
   localparam logic [INT_W-1:0] INT_RESET = 12'h000;
   localparam logic [RES_W-1:0] RES_RESET = 10'h000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [CHAN_W-1:0] LAST_CHAN = 2'h3;
   localparam logic [MAG_W-1:0] MAG_MAX = 7'h7F;

   // ==========================================================
   // Channel sequencer states
   typedef enum logic [1:0]
   {
      SEQ_IDLE = 2'b00,
      SEQ_SETUP = 2'b01,
      SEQ_REQ = 2'b10
   } seq_state_e;

endpackage

// file: sign_mag_format.sv
// Two's complement offset to sign-magnitude converter with saturation
`timescale 1ns/1ps
module sign_mag_format
(
   // Raw offset from the front end
   input wire logic [7:0] raw_i,
   // Sign-magnitude byte
   output logic [7:0] sm_o
);

   wire logic neg;
   wire logic [7:0] absval;
   wire logic [color_sensor_pkg::MAG_W-1:0] mag;

   assign neg = raw_i[color_sensor_pkg::SIGN_BIT];
   assign absval = neg ? 8'(~raw_i + 8'h01) : raw_i;
   // Minus 128 has no 7-bit magnitude, so it saturates
   assign mag = absval[color_sensor_pkg::SIGN_BIT] ?
      color_sensor_pkg::MAG_MAX : absval[color_sensor_pkg::MAG_W-1:0];
   assign sm_o = {neg, mag};

endmodule

// file: channel_sequencer.sv
// Walks the four channels through the analog front end, one at a time
`timescale 1ns/1ps
module channel_sequencer
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Control from the register block
   input wire logic start_i,
   input wire logic offset_mode_i,
   // Front end handshake
   input wire logic ack_i,
   output logic req_o,
   output logic [color_sensor_pkg::CHAN_W-1:0] chan_o,
   output logic offset_mode_o,
   // One-cycle pulse after the last channel is stored
   output logic done_o
);

   localparam int CHAN_W = color_sensor_pkg::CHAN_W;

   color_sensor_pkg::seq_state_e state_reg, state_next;
   logic [color_sensor_pkg::CHAN_W-1:0] chan_next;
   logic req_next;
   logic mode_next;
   logic done_next;

   always_comb
   begin
      state_next = state_reg;
      chan_next = chan_o;
      req_next = req_o;
      mode_next = offset_mode_o;
      done_next = 1'b0;
      case (state_reg)
         color_sensor_pkg::SEQ_IDLE:
         begin
            if (start_i)
            begin
               state_next = color_sensor_pkg::SEQ_SETUP;
               chan_next = '0;
               mode_next = offset_mode_i;
            end
         end
         // Gives the top a cycle to present this channel's settings
         color_sensor_pkg::SEQ_SETUP:
         begin
            state_next = color_sensor_pkg::SEQ_REQ;
            req_next = 1'b1;
         end
         color_sensor_pkg::SEQ_REQ:
         begin
            if (ack_i)
            begin
               req_next = 1'b0;
               if (chan_o == color_sensor_pkg::LAST_CHAN)
               begin
                  state_next = color_sensor_pkg::SEQ_IDLE;
                  done_next = 1'b1;
               end
               else
               begin
                  state_next = color_sensor_pkg::SEQ_SETUP;
                  chan_next = CHAN_W'(chan_o + 2'h1);
               end
            end
         end
         default:
         begin
            state_next = color_sensor_pkg::SEQ_IDLE;
            req_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= color_sensor_pkg::SEQ_IDLE;
         chan_o <= '0;
         req_o <= 1'b0;
         offset_mode_o <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         chan_o <= chan_next;
         req_o <= req_next;
         offset_mode_o <= mode_next;
         done_o <= done_next;
      end
   end

endmodule

// file: color_sensor_checker.sv
// Concurrent checks on the colour sensor register block ports
`timescale 1ns/1ps
module color_sensor_checker
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // Front end and control outputs
   input wire logic afe_ack_i,
   input wire logic afe_req_o,
   input wire logic afe_offset_mode_o,
   input wire logic [1:0] afe_chan_o,
   input wire logic [3:0] afe_cap_o,
   input wire logic [11:0] afe_int_o,
   input wire logic ext_clock_select_o,
   input wire logic sleep_o,
   input wire logic trim_offset_enable_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   logic cfg_wr;
   assign cfg_wr = reg_wr_i && reg_addr_i == color_sensor_pkg::ADDR_CONFIG;
   // ==========================================================
   // Front end handshake
   sequence ack_s;
      afe_req_o && afe_ack_i;
   endsequence
   sequence last_ack_s;
      ack_s ##0 afe_chan_o == 2'h3;
   endsequence
   req_hold_a: assert property (afe_req_o && !afe_ack_i |=> afe_req_o
      && $stable({afe_chan_o, afe_offset_mode_o, afe_cap_o, afe_int_o}))
      else $error("request dropped or changed before answer");
   req_drop_a: assert property (ack_s |=> !afe_req_o)
      else $error("request still high after answer");
   chan_step_a: assert property (ack_s ##0 afe_chan_o != 2'h3
      |=> afe_chan_o == $past(afe_chan_o) + 2'h1)
      else $error("channel did not advance after answer");
   seq_end_a: assert property (last_ack_s |=> !afe_req_o [*2])
      else $error("request raised right after last channel");
   // ==========================================================
   // Configuration
   ext_write_a: assert property (cfg_wr
      |=> ext_clock_select_o == $past(reg_wdata_i[2]))
      else $error("external clock select not taken from write");
   sleep_write_a: assert property (cfg_wr
      |=> sleep_o == $past(reg_wdata_i[1] & reg_wdata_i[2]))
      else $error("sleep not qualified by external clock");
   sleep_ext_a: assert property (sleep_o |-> ext_clock_select_o)
      else $error("sleep set without external clock");
   trim_write_a: assert property (cfg_wr
      |=> trim_offset_enable_o == $past(reg_wdata_i[0]))
      else $error("trim enable not taken from write");
   // ==========================================================
   // Unavailable bits read as zero
   cap_read_a: assert property (reg_rd_i && reg_addr_i >= 8'h06
      && reg_addr_i <= 8'h09 |=> reg_rdata_o[7:4] == 4'h0)
      else $error("capacitor upper bits not zero");
   data_read_a: assert property (reg_rd_i && reg_addr_i[7:3] == 5'h08
      && reg_addr_i[0] |=> reg_rdata_o[7:2] == 6'h00)
      else $error("result high byte upper bits not zero");
endmodule

bind color_sensor_regs color_sensor_checker chk
(
   .sys_clk_i(sys_clk_i),
   .rst_i(rst_i),
   .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o),
   .afe_ack_i(afe_ack_i),
   .afe_req_o(afe_req_o),
   .afe_offset_mode_o(afe_offset_mode_o),
   .afe_chan_o(afe_chan_o),
   .afe_cap_o(afe_cap_o),
   .afe_int_o(afe_int_o),
   .ext_clock_select_o(ext_clock_select_o),
   .sleep_o(sleep_o),
   .trim_offset_enable_o(trim_offset_enable_o)
);

// file: color_front_end_model.sv
// Behavioural analog front end answering channel requests
`timescale 1ns/1ps
module color_front_end_model
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Request side
   input wire logic req_i,
   input wire logic offset_mode_i,
   input wire logic [1:0] chan_i,
   input wire logic [3:0] cap_i,
   input wire logic [11:0] int_i,
   // Answer side
   output logic ack_o,
   output logic [9:0] result_o
);
   localparam logic [7:0] OFS_RAW [4] = '{8'h05, 8'hFD, 8'h80, 8'h7F};
   logic [3:0] wait_reg;
   logic [3:0] seen_cap [4];
   logic [11:0] seen_int [4];
   logic [9:0] answer;
   assign answer = offset_mode_i ? {2'b00, OFS_RAW[chan_i]}
      : {chan_i, 8'h3C} + {8'h00, chan_i};
   // Later channels answer slower so the held request is exercised
   always @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         wait_reg <= 4'h0;
         result_o <= 10'h3FF;
      end
      else if (req_i && !ack_o && wait_reg >= {1'b0, chan_i, 1'b0})
      begin
         ack_o <= 1'b1;
         result_o <= answer;
         seen_cap[chan_i] <= cap_i;
         seen_int[chan_i] <= int_i;
         wait_reg <= 4'h0;
      end
      else
      begin
         // Result is not held once the answer is gone
         ack_o <= 1'b0;
         result_o <= ~result_o;
         wait_reg <= (req_i && !ack_o) ? wait_reg + 4'h1 : 4'h0;
      end
   end
endmodule

// file: color_sensor_regs_bench.sv
// Self-checking testbench of the colour sensor register block
`timescale 1ns/1ps
module color_sensor_regs_bench;
   localparam logic [9:0] CONV [4] = '{10'h03C, 10'h13D, 10'h23E, 10'h33F};
   localparam logic [9:0] TRIM [4] = '{10'h037, 10'h140, 10'h2BD, 10'h2C0};
   localparam logic [7:0] SM [4] = '{8'h05, 8'h83, 8'hFF, 8'h7F};
   logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, afe_ack_i, afe_req_o;
   logic afe_offset_mode_o, ext_clock_select_o, sleep_o;
   logic trim_offset_enable_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v, a;
   logic [9:0] afe_result_i;
   logic [1:0] afe_chan_o;
   logic [3:0] afe_cap_o;
   logic [11:0] afe_int_o;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   color_sensor_regs uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .afe_ack_i(afe_ack_i), .afe_result_i(afe_result_i),
      .afe_req_o(afe_req_o), .afe_offset_mode_o(afe_offset_mode_o),
      .afe_chan_o(afe_chan_o), .afe_cap_o(afe_cap_o), .afe_int_o(afe_int_o),
      .ext_clock_select_o(ext_clock_select_o), .sleep_o(sleep_o),
      .trim_offset_enable_o(trim_offset_enable_o));
   color_front_end_model fe (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .req_i(afe_req_o), .offset_mode_i(afe_offset_mode_o),
      .chan_i(afe_chan_o), .cap_i(afe_cap_o), .int_i(afe_int_o),
      .ack_o(afe_ack_i), .result_o(afe_result_i));
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // ==========================================================
   // Checking and closing
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Hang guard, well above the expected run length
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         print_verdict();
      end
   end
   // ==========================================================
   // Register access
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= ad;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      // Lets the write settle before a caller looks at the outputs
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
      @(posedge sys_clk_i);
      reg_addr_i <= ad;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
      check(v, e);
   endtask
   // Polls the command register until the given bit self-clears
   task automatic wait_cmd(input int b);
      for (int n = 0; n < 60; n++)
      begin
         @(posedge sys_clk_i);
         reg_addr_i <= color_sensor_pkg::ADDR_CTRL;
         reg_rd_i <= 1'b1;
         @(posedge sys_clk_i);
         reg_rd_i <= 1'b0;
         #1 v = reg_rdata_o;
         if (v[b] === 1'b0)
            return;
      end
      check(v, 12'hFFF);
   endtask
   task automatic chk_data(input logic [9:0] e [4]);
      for (int i = 0; i < 4; i++)
      begin
         a = color_sensor_pkg::ADDR_DATA_BASE + 8'(2 * i);
         rd_chk(a, e[i][7:0]);
         rd_chk(a + 8'h01, {6'h00, e[i][9:8]});
      end
   endtask
   // ==========================================================
   // Test sequence
   initial
   begin
      rst_i = 1'b1;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      repeat (20) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8'h50; i++)
         rd_chk(8'(i), (i >= 6 && i <= 9) ? 8'h0F : 8'h00);
      $display("reset values done");
      for (int i = 0; i < 4; i++)
      begin
         a = color_sensor_pkg::ADDR_CAP_BASE + 8'(i);
         wr(a, 8'hF8 + 8'(i));
         rd_chk(a, 8'h08 + 8'(i));
         a = color_sensor_pkg::ADDR_INT_BASE + 8'(2 * i);
         wr(a, 8'hA0 + 8'(i));
         wr(a + 8'h01, 8'hF0 + 8'(i));
         rd_chk(a, 8'hA0 + 8'(i));
         rd_chk(a + 8'h01, 8'(i));
      end
      wr(color_sensor_pkg::ADDR_DATA_BASE, 8'hFF);
      rd_chk(color_sensor_pkg::ADDR_DATA_BASE, 8'h00);
      $display("register layout done");
      wr(color_sensor_pkg::ADDR_CTRL, 8'h01);
      wait_cmd(0);
      chk_data(CONV);
      for (int i = 0; i < 4; i++)
      begin
         check(fe.seen_cap[i], 12'h008 + 12'(i));
         check(fe.seen_int[i], {i[3:0], 8'hA0 + 8'(i)});
      end
      $display("conversion done");
      wr(color_sensor_pkg::ADDR_CTRL, 8'h02);
      wait_cmd(1);
      for (int i = 0; i < 4; i++)
         rd_chk(color_sensor_pkg::ADDR_OFS_BASE + 8'(i), SM[i]);
      $display("offset done");
      wr(color_sensor_pkg::ADDR_CONFIG, 8'h01);
      check(trim_offset_enable_o, 1'b1);
      wr(color_sensor_pkg::ADDR_CTRL, 8'h01);
      wait_cmd(0);
      chk_data(TRIM);
      $display("trim done");
      wr(color_sensor_pkg::ADDR_CONFIG, 8'h02);
      rd_chk(color_sensor_pkg::ADDR_CONFIG, 8'h00);
      wr(color_sensor_pkg::ADDR_CONFIG, 8'h06);
      rd_chk(color_sensor_pkg::ADDR_CONFIG, 8'h06);
      check({ext_clock_select_o, sleep_o}, 2'b11);
      wr(color_sensor_pkg::ADDR_CTRL, 8'h03);
      repeat (10) @(posedge sys_clk_i);
      check(afe_req_o, 1'b0);
      rd_chk(color_sensor_pkg::ADDR_CTRL, 8'h03);
      wr(color_sensor_pkg::ADDR_CONFIG, 8'h04);
      check({ext_clock_select_o, sleep_o}, 2'b10);
      wait_cmd(0);
      wait_cmd(1);
      chk_data(CONV);
      $display("sleep done");
      print_verdict();
   end
endmodule
